// ---- src/rmlc_top.v ----
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rmlc_defs.vh"
module rmlc_top #(
    parameter SLOT_CYC = `RMLC_SLOT_CYC
) (
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // host character stream, same clock
    input wire hin_valid,
    input wire [7:0] hin_data,
    input wire hin_par,
    output wire hin_ready,
    output reg hout_valid,
    output reg [7:0] hout_data,
    output reg hout_par,
    input wire hout_ready,
    // host line pins for the transparent mode
    input wire host_rxd_pin,
    output reg host_txd_pin,
    // host port format
    output reg [2:0] host_baud_code,
    output reg host_par_en,
    // peer link, byte path
    output reg lnk_tx_valid,
    output reg [7:0] lnk_tx_data,
    output reg lnk_tx_par,
    input wire lnk_tx_ready,
    input wire lnk_rx_valid,
    input wire [7:0] lnk_rx_data,
    input wire lnk_rx_par,
    output reg lnk_rx_ready,
    // peer link, line samples
    output reg lnk_smp_tx_valid,
    output reg lnk_smp_tx_bit,
    input wire lnk_smp_rx_valid,
    input wire lnk_smp_rx_bit,
    // transmitter keyed
    output reg rf_tx_on
);
    localparam [31:0] SMP_W = `RMLC_SMP_CYC;
    localparam [31:0] SLOT_W = SLOT_CYC - 1;
    localparam [10:0] SMP_CYC = SMP_W[10:0];
    localparam [17:0] SLOT_LAST = SLOT_W[17:0];

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    reg [10:0] ctrl_r;
    reg par_err_r;
    wire [1:0] mode = ctrl_r[`RMLC_CTRL_MODE_LSB+1:`RMLC_CTRL_MODE_LSB];
    wire master = ctrl_r[`RMLC_CTRL_MASTER];
    wire half = ctrl_r[`RMLC_CTRL_HALF];
    wire syncm = ctrl_r[`RMLC_CTRL_SYNC];
    wire even = ctrl_r[`RMLC_CTRL_EVEN];
    wire cfg_mode = ctrl_r[`RMLC_CTRL_CFG];
    wire multi = ctrl_r[`RMLC_CTRL_MULTI];
    wire [2:0] baud = ctrl_r[`RMLC_CTRL_BAUD_LSB+2:`RMLC_CTRL_BAUD_LSB];

    //------------------------------------------------------------
    // setting checks
    //------------------------------------------------------------
    reg cfg_ok;
    always @* begin
        case (mode)
            `RMLC_MODE_TRANSP:
                cfg_ok = !half && !syncm && baud <= `RMLC_BAUD_9600 && !multi;
            `RMLC_MODE_EMUFD:
                cfg_ok = !half && syncm && baud <= `RMLC_BAUD_57600 && !multi;
            `RMLC_MODE_CMDRSP:
                cfg_ok = half && syncm && !master;
            default:
                cfg_ok = 1'b0;
        endcase
    end
    // link work only with valid settings and outside configuration mode
    wire run = cfg_ok && !cfg_mode;
    wire run1 = run && (mode == `RMLC_MODE_TRANSP);
    wire run2 = run && (mode == `RMLC_MODE_EMUFD);
    wire run3 = run && (mode == `RMLC_MODE_CMDRSP);

    //------------------------------------------------------------
    // apb slave, no wait states
    //------------------------------------------------------------
    wire acc = psel && penable && pready;
    wire hit_ctrl = (paddr == `RMLC_OFS_CTRL);
    wire hit_stat = (paddr == `RMLC_OFS_STAT);
    reg tx_phase_r;
    reg armed_r;
    wire buf_ov;
    wire [31:0] stat_v = {26'h0, par_err_r, buf_ov, ~cfg_ok, armed_r, tx_phase_r, run};
    wire par_bad;

    // ready rises in the access phase; data and error load with it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !hit_ctrl && !hit_stat;
            if (psel && !penable) begin
                prdata <= hit_ctrl ? {21'h0, ctrl_r} : (hit_stat ? stat_v : 32'h0);
            end
        end
    end

    // control write; parity error sticky, write one to clear, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `RMLC_CTRL_RESET;
            par_err_r <= 1'b0;
        end else begin
            if (acc && pwrite && hit_ctrl) begin
                ctrl_r <= pwdata[10:0];
            end
            if (par_bad) begin
                par_err_r <= 1'b1;
            end else if (acc && pwrite && hit_stat && pwdata[`RMLC_STAT_PARERR]) begin
                par_err_r <= 1'b0;
            end
        end
    end

    // host format; configuration mode overrides the working settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_baud_code <= `RMLC_BAUD_9600;
            host_par_en <= 1'b0;
        end else begin
            host_baud_code <= cfg_mode ? `RMLC_BAUD_9600 : baud;
            host_par_en <= cfg_mode ? 1'b0 : even;
        end
    end

    //------------------------------------------------------------
    // transparent mode: line sampling and rebuild
    //------------------------------------------------------------
    wire rxd_s;
    reg [10:0] smp_cnt_r;
    wire smp_tick = (smp_cnt_r == SMP_CYC - 11'h1);

    rmlc_sync #(.W(1)) u_rxd_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(host_rxd_pin),
        .q(rxd_s)
    );

    // a 32 kHz tick; the line format is never looked at here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_cnt_r <= 11'h0;
            lnk_smp_tx_valid <= 1'b0;
            lnk_smp_tx_bit <= 1'b1;
            host_txd_pin <= 1'b1;
        end else begin
            smp_cnt_r <= (!run1 || smp_tick) ? 11'h0 : smp_cnt_r + 11'h1;
            lnk_smp_tx_valid <= run1 && smp_tick;
            if (run1 && smp_tick) begin
                lnk_smp_tx_bit <= rxd_s;
            end
            // idle line high whenever the mode is not running
            if (!run1) begin
                host_txd_pin <= 1'b1;
            end else if (lnk_smp_rx_valid) begin
                host_txd_pin <= lnk_smp_rx_bit;
            end
        end
    end

    //------------------------------------------------------------
    // emulated full duplex: slot timer
    //------------------------------------------------------------
    reg [17:0] slot_cnt_r;
    reg ph_r;

    // equal slots; master opens in transmit, slave in receive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_r <= 18'h0;
            ph_r <= 1'b1;
        end else if (!run2) begin
            slot_cnt_r <= 18'h0;
            ph_r <= 1'b1;
        end else if (slot_cnt_r == SLOT_LAST) begin
            slot_cnt_r <= 18'h0;
            ph_r <= ~ph_r;
        end else begin
            slot_cnt_r <= slot_cnt_r + 18'h1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_phase_r <= 1'b0;
        end else begin
            tx_phase_r <= run2 && (master ? ph_r : ~ph_r);
        end
    end

    //------------------------------------------------------------
    // host byte path into the two-entry buffer
    //------------------------------------------------------------
    // even parity checked only where the character format is fixed
    wire byte_mode = run2 || run3;
    assign par_bad = hin_valid && hin_ready && byte_mode && even
                     && (^{hin_data, hin_par});
    wire buf_iv = hin_valid && byte_mode && !par_bad;
    wire buf_in_rdy;
    wire [8:0] buf_od;
    wire gate;
    wire load = buf_ov && gate && (!lnk_tx_valid || lnk_tx_ready);

    // a bad character is swallowed rather than stalling the host
    assign hin_ready = buf_in_rdy;

    rmlc_buf2 #(.W(9)) u_tx_buf (
        .pclk(pclk),
        .presetn(presetn),
        .flush(!byte_mode),
        .in_valid(buf_iv),
        .in_data({even & hin_par, hin_data}),
        .in_ready(buf_in_rdy),
        .out_valid(buf_ov),
        .out_data(buf_od),
        .out_ready(load)
    );

    //------------------------------------------------------------
    // half duplex: transmit only after a received command
    //------------------------------------------------------------
    wire rx_take = lnk_rx_valid && lnk_rx_ready;

    // armed by any command; drops once the reply drains, new command wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
        end else if (!run3) begin
            armed_r <= 1'b0;
        end else if (rx_take) begin
            armed_r <= 1'b1;
        end else if (lnk_tx_valid && lnk_tx_ready && !buf_ov) begin
            armed_r <= 1'b0;
        end
    end

    // slave holds data in the buffer until its own slot opens
    assign gate = tx_phase_r || (run3 && armed_r);

    //------------------------------------------------------------
    // link transmit register
    //------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk_tx_valid <= 1'b0;
            lnk_tx_data <= 8'h0;
            lnk_tx_par <= 1'b0;
            rf_tx_on <= 1'b0;
        end else begin
            if (load) begin
                lnk_tx_valid <= 1'b1;
                lnk_tx_data <= buf_od[7:0];
                lnk_tx_par <= buf_od[8];
            end else if (lnk_tx_ready || !byte_mode) begin
                lnk_tx_valid <= 1'b0;
            end
            // keyed in own slot, during a reply, or while sampling
            rf_tx_on <= tx_phase_r || (run3 && armed_r) || run1;
        end
    end

    //------------------------------------------------------------
    // link receive into host output register
    //------------------------------------------------------------
    // received bytes delivered in both emulated and half duplex modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hout_valid <= 1'b0;
            hout_data <= 8'h0;
            hout_par <= 1'b0;
            lnk_rx_ready <= 1'b0;
        end else begin
            if (rx_take) begin
                hout_valid <= 1'b1;
                hout_data <= lnk_rx_data;
                hout_par <= even & lnk_rx_par;
                lnk_rx_ready <= 1'b0;
            end else begin
                if (hout_ready || !byte_mode) begin
                    hout_valid <= 1'b0;
                end
                lnk_rx_ready <= byte_mode && (!hout_valid || hout_ready);
            end
        end
    end
endmodule // rmlc_top
`default_nettype wire

// ---- include/rmlc_defs.vh ----
//------------------------------------------------------------
// radio modem link mode control: constants
//------------------------------------------------------------
// Behaviour
// - transparent mode samples host line at fixed rate; peer rebuilds the waveform.
// - transparent mode needs full-duplex, asynchronous, baud at most 9600, one master.
// - emulated full-duplex master starts transmitting, switches to receive after 4 ms.
// - emulated full-duplex slave runs the opposite phase to the master.
// - slave buffers host data during master transmit phase, sends it afterwards.
// - emulated full-duplex characters are 8 data, 1 stop, no or even parity.
// - emulated full-duplex needs full-duplex, synchronous, one master, baud at most 57600.
// - half-duplex mode transmits only as response to a received command.
// - networks of more than two modems use only the half-duplex mode.
// - half-duplex characters are 8 data, 1 stop, no or even parity.
// - half-duplex mode needs half-duplex, synchronous, every modem a slave.
// - configuration mode forces host port to 9600 bps, 8 data, no parity.
`ifndef RMLC_DEFS_VH
`define RMLC_DEFS_VH

//------------------------------------------------------------
// register offsets (byte addresses)
//------------------------------------------------------------
`define RMLC_OFS_CTRL 12'h000
`define RMLC_OFS_STAT 12'h004

//------------------------------------------------------------
// control fields
//------------------------------------------------------------
`define RMLC_CTRL_MODE_LSB 0
`define RMLC_CTRL_MASTER 2
`define RMLC_CTRL_HALF 3
`define RMLC_CTRL_SYNC 4
`define RMLC_CTRL_EVEN 5
`define RMLC_CTRL_CFG 6
`define RMLC_CTRL_MULTI 7
`define RMLC_CTRL_BAUD_LSB 8
`define RMLC_CTRL_RESET 11'h040

//------------------------------------------------------------
// status fields
//------------------------------------------------------------
`define RMLC_STAT_RUN 0
`define RMLC_STAT_TXPH 1
`define RMLC_STAT_ARMED 2
`define RMLC_STAT_CFGERR 3
`define RMLC_STAT_BUFV 4
`define RMLC_STAT_PARERR 5

//------------------------------------------------------------
// modes and baud codes
//------------------------------------------------------------
`define RMLC_MODE_IDLE 2'h0
`define RMLC_MODE_TRANSP 2'h1
`define RMLC_MODE_EMUFD 2'h2
`define RMLC_MODE_CMDRSP 2'h3
`define RMLC_BAUD_9600 3'h0
`define RMLC_BAUD_57600 3'h3

//------------------------------------------------------------
// timing
//------------------------------------------------------------
`define RMLC_CLK_HZ 40000000
`define RMLC_SAMPLE_HZ 32000
`define RMLC_SMP_CYC (`RMLC_CLK_HZ / `RMLC_SAMPLE_HZ)
`define RMLC_SLOT_US 4000
`define RMLC_SLOT_CYC (`RMLC_CLK_HZ / 1000000 * `RMLC_SLOT_US)

`endif

// ---- src/rmlc_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for asynchronous pin levels
module rmlc_sync #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // rmlc_sync
`default_nettype wire

// ---- src/rmlc_buf2.v ----
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; in_ready and out_valid come from flops
module rmlc_buf2 #(
    parameter W = 9
) (
    input wire pclk,
    input wire presetn,
    input wire flush,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg in_ready,
    output reg out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] mem_r [0:1];
    reg rd_r;
    reg wr_r;
    reg [1:0] cnt_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [1:0] cnt_nxt = flush ? 2'h0 : cnt_r + {1'b0, push} - {1'b0, pop};

    assign out_data = mem_r[rd_r];

    // storage is not reset; only pointers and flags need defined values
    always @(posedge pclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cnt_r <= 2'h0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            rd_r <= flush ? 1'b0 : rd_r ^ pop;
            wr_r <= flush ? 1'b0 : wr_r ^ push;
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != 2'h2);
            out_valid <= (cnt_nxt != 2'h0);
        end
    end
endmodule // rmlc_buf2
`default_nettype wire

// ---- sim/rmlc_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmlc_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hout_valid,
    input wire logic [7:0] hout_data,
    input wire logic hout_ready,
    input wire logic lnk_tx_valid,
    input wire logic [7:0] lnk_tx_data,
    input wire logic lnk_tx_ready,
    input wire logic lnk_rx_valid,
    input wire logic lnk_rx_ready,
    input wire logic lnk_smp_tx_valid,
    input wire logic lnk_smp_rx_valid,
    input wire logic lnk_smp_rx_bit,
    input wire logic host_txd_pin,
    input wire logic rf_tx_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // gap since last sample; first pulse of a run is not measured
    logic [11:0] gap_r;
    logic seen_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 12'h000;
            seen_r <= 1'b0;
        end else begin
            gap_r <= lnk_smp_tx_valid ? 12'h001 : gap_r + 12'h001;
            seen_r <= (seen_r | lnk_smp_tx_valid) & rf_tx_on;
        end
    end
    //----------------------------------------
    // bus and stream checks
    //----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_pready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
    a_pready_one_pulse: assert property (s_done |=> !pready) else $error("ready too long");
    a_bad_addr_err: assert property (s_done ##0 (paddr != 12'h000 && paddr != 12'h004)
        |-> pslverr && prdata == 32'h0) else $error("no slverr");
    a_good_addr_ok: assert property (s_done ##0 (paddr == 12'h000 || paddr == 12'h004)
        |-> !pslverr) else $error("stray slverr");
    a_link_tx_hold: assert property (lnk_tx_valid && !lnk_tx_ready |=> lnk_tx_valid
        && $stable(lnk_tx_data)) else $error("link byte lost");
    a_host_out_hold: assert property (hout_valid && !hout_ready |=> hout_valid
        && $stable(hout_data)) else $error("host byte lost");
    a_rx_ready_gap: assert property (lnk_rx_valid && lnk_rx_ready |=> !lnk_rx_ready)
        else $error("rx ready held");
    a_rx_to_host: assert property (lnk_rx_valid && lnk_rx_ready && !hout_valid |=> hout_valid)
        else $error("rx not passed on");
    a_sample_period: assert property (lnk_smp_tx_valid && seen_r |-> gap_r == 12'h4e2)
        else $error("sample period off");
    a_rebuild_line: assert property (lnk_smp_rx_valid |=> host_txd_pin == $past(lnk_smp_rx_bit))
        else $error("line not rebuilt");
    a_keyed_sampling: assert property (lnk_smp_tx_valid |-> rf_tx_on)
        else $error("sample while unkeyed");
endmodule // rmlc_top_monitor
bind rmlc_top rmlc_top_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hout_valid(hout_valid), .hout_data(hout_data), .hout_ready(hout_ready),
    .lnk_tx_valid(lnk_tx_valid), .lnk_tx_data(lnk_tx_data), .lnk_tx_ready(lnk_tx_ready),
    .lnk_rx_valid(lnk_rx_valid), .lnk_rx_ready(lnk_rx_ready),
    .lnk_smp_tx_valid(lnk_smp_tx_valid), .lnk_smp_rx_valid(lnk_smp_rx_valid),
    .lnk_smp_rx_bit(lnk_smp_rx_bit), .host_txd_pin(host_txd_pin), .rf_tx_on(rf_tx_on));
`default_nettype wire

// ---- sim/rmlc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmlc_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic lnk_tx_valid,
    input wire logic [7:0] lnk_tx_data,
    input wire logic lnk_tx_par,
    input wire logic lnk_rx_ready,
    input wire logic lnk_smp_tx_valid,
    input wire logic lnk_smp_tx_bit,
    output logic lnk_tx_ready,
    output logic lnk_rx_valid,
    output logic [7:0] lnk_rx_data,
    output logic lnk_rx_par,
    output logic lnk_smp_rx_valid,
    output logic lnk_smp_rx_bit
);
    logic [8:0] got [$];
    initial {lnk_rx_valid, lnk_rx_data, lnk_rx_par} = 10'h000;
    // accept bytes, loop line samples back as a rebuilding peer would
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk_tx_ready <= 1'b0;
            lnk_smp_rx_valid <= 1'b0;
            lnk_smp_rx_bit <= 1'b1;
        end else begin
            lnk_tx_ready <= !stall;
            if (lnk_tx_valid && lnk_tx_ready) got.push_back({lnk_tx_par, lnk_tx_data});
            lnk_smp_rx_valid <= lnk_smp_tx_valid;
            // between samples the bit wanders, so stale use shows up
            lnk_smp_rx_bit <= lnk_smp_tx_valid ? lnk_smp_tx_bit : ~lnk_smp_rx_bit;
        end
    end
    // command from the far modem, even parity, line scrambled after
    task send_cmd(input logic [7:0] b);
        integer n;
        begin
            @(posedge pclk);
            lnk_rx_valid <= 1'b1;
            lnk_rx_data <= b;
            lnk_rx_par <= ^b;
            @(posedge pclk);
            for (n = 0; lnk_rx_ready !== 1'b1 && n < 200; n++) @(posedge pclk);
            lnk_rx_valid <= 1'b0;
            lnk_rx_data <= ~b;
        end
    endtask
endmodule // rmlc_peer
`default_nettype wire

// ---- sim/rmlc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmlc_top_tb_top;
    localparam int SLOT = 40;
    logic pclk, presetn, psel, penable, pwrite, hin_valid, hin_par, hout_ready, host_rxd_pin;
    logic stall, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    logic [7:0] hin_data;
    wire [31:0] prdata;
    wire [7:0] hout_data, lnk_tx_data, lnk_rx_data;
    wire [2:0] host_baud_code;
    wire pready, pslverr, hin_ready, hout_valid, hout_par, host_txd_pin, host_par_en, rf_tx_on;
    wire lnk_tx_valid, lnk_tx_par, lnk_tx_ready, lnk_rx_valid, lnk_rx_par, lnk_rx_ready;
    wire lnk_smp_tx_valid, lnk_smp_tx_bit, lnk_smp_rx_valid, lnk_smp_rx_bit;
    integer errors, tests_run, cyc, i, n, t0, tf, tr;
    logic [31:0] bad [6] = '{32'h305, 32'h015, 32'h396, 32'h31e, 32'h31f, 32'h30b};
    rmlc_top #(.SLOT_CYC(SLOT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hin_valid(hin_valid), .hin_data(hin_data),
        .hin_par(hin_par), .hin_ready(hin_ready), .hout_valid(hout_valid),
        .hout_data(hout_data), .hout_par(hout_par), .hout_ready(hout_ready),
        .host_rxd_pin(host_rxd_pin), .host_txd_pin(host_txd_pin),
        .host_baud_code(host_baud_code), .host_par_en(host_par_en),
        .lnk_tx_valid(lnk_tx_valid), .lnk_tx_data(lnk_tx_data), .lnk_tx_par(lnk_tx_par),
        .lnk_tx_ready(lnk_tx_ready), .lnk_rx_valid(lnk_rx_valid), .lnk_rx_data(lnk_rx_data),
        .lnk_rx_par(lnk_rx_par), .lnk_rx_ready(lnk_rx_ready),
        .lnk_smp_tx_valid(lnk_smp_tx_valid), .lnk_smp_tx_bit(lnk_smp_tx_bit),
        .lnk_smp_rx_valid(lnk_smp_rx_valid), .lnk_smp_rx_bit(lnk_smp_rx_bit),
        .rf_tx_on(rf_tx_on));
    rmlc_peer PEER (.pclk(pclk), .presetn(presetn), .stall(stall),
        .lnk_tx_valid(lnk_tx_valid), .lnk_tx_data(lnk_tx_data), .lnk_tx_par(lnk_tx_par),
        .lnk_rx_ready(lnk_rx_ready), .lnk_smp_tx_valid(lnk_smp_tx_valid),
        .lnk_smp_tx_bit(lnk_smp_tx_bit), .lnk_tx_ready(lnk_tx_ready),
        .lnk_rx_valid(lnk_rx_valid), .lnk_rx_data(lnk_rx_data), .lnk_rx_par(lnk_rx_par),
        .lnk_smp_rx_valid(lnk_smp_rx_valid), .lnk_smp_rx_bit(lnk_smp_rx_bit));
    //----------------------------------------
    // clock, cycle count, helpers
    //----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("BAD t=%0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task tmo(input integer k);
        begin
            if (k >= 400) begin
                errors = errors + 1;
                $display("BAD t=%0t wait ran out", $time);
                tally_and_finish;
            end
        end
    endtask
    // apb transfer; answer taken at the edge that sees pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (n = 0; pready !== 1'b1 && n < 400; n++) @(posedge pclk);
            tmo(n);
            q = prdata;
            perr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task push(input logic [7:0] b, input logic p);
        begin
            @(posedge pclk);
            hin_valid <= 1'b1;
            hin_data <= b;
            hin_par <= p;
            @(posedge pclk);
            for (n = 0; hin_ready !== 1'b1 && n < 400; n++) @(posedge pclk);
            tmo(n);
            hin_valid <= 1'b0;
        end
    endtask
    task wait_got(input integer k);
        begin
            for (n = 0; PEER.got.size() < k && n < 400; n++) @(negedge pclk);
            tmo(n);
        end
    endtask
    // a hang anywhere ends the run as a failure
    initial begin
        #2500000;
        tmo(400);
    end
    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        {psel, penable, pwrite, hin_valid, hin_par, hout_ready, stall, presetn} = 8'h00;
        {paddr, pwdata, hin_data, host_rxd_pin} = 53'h1;
        {errors, tests_run, cyc} = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 32'h0);
        chk(q, 32'h040);
        chk({host_baud_code, host_par_en}, 32'h0);
        apb(0, 12'h008, 32'h0);
        chk(q, 32'h0);
        chk(perr, 32'h1);
        apb(1, 12'h000, 32'h376);
        apb(0, 12'h000, 32'h0);
        chk(q, 32'h376);
        chk({host_baud_code, host_par_en}, 32'h0);
        for (i = 0; i < 6; i++) begin
            apb(1, 12'h000, bad[i]);
            apb(0, 12'h004, 32'h0);
            chk(q[3:0] & 4'h9, 32'h8);
        end
        $display("register and settings test done");
        apb(1, 12'h000, 32'h336);
        repeat (2) @(posedge pclk);
        chk({host_baud_code, host_par_en}, 32'h7);
        t0 = cyc;
        {tf, tr} = 0;
        for (i = 0; i < 200 && tr == 0; i++) begin
            apb(0, 12'h004, 32'h0);
            if (i == 0) chk(q[1:0], 32'h3);
            if (q[1] === 1'b0 && tf == 0) tf = cyc;
            if (q[1] === 1'b1 && tf != 0) tr = cyc;
        end
        chk((tf - t0) >= SLOT - 6 && (tf - t0) <= SLOT + 6, 32'h1);
        chk((tr - tf) >= SLOT - 6 && (tr - tf) <= SLOT + 6, 32'h1);
        push(8'ha5, 1'b1);
        push(8'ha5, 1'b0);
        wait_got(1);
        chk(PEER.got[0], 32'h0a5);
        apb(0, 12'h004, 32'h0);
        chk(q[5], 32'h1);
        apb(1, 12'h004, 32'h20);
        apb(0, 12'h004, 32'h0);
        chk(q[5], 32'h0);
        PEER.got.delete();
        apb(1, 12'h000, 32'h332);
        apb(0, 12'h004, 32'h0);
        chk(q[1:0], 32'h1);
        push(8'h3c, 1'b0);
        apb(0, 12'h004, 32'h0);
        chk({q[4], q[1], PEER.got.size() != 0}, 32'h4);
        wait_got(1);
        chk(PEER.got[0], 32'h03c);
        $display("emulated duplex test done");
        PEER.got.delete();
        stall <= 1'b1;
        apb(1, 12'h000, 32'h31b);
        push(8'h11, 1'b0);
        push(8'h22, 1'b0);
        repeat (3) @(negedge pclk);
        chk({hin_ready, lnk_tx_valid}, 32'h0);
        PEER.send_cmd(8'h5e);
        @(negedge pclk);
        chk({hout_valid, hout_par, hout_data}, 32'h25e);
        repeat (3) @(posedge pclk);
        hout_ready <= 1'b1;
        stall <= 1'b0;
        @(posedge pclk);
        hout_ready <= 1'b0;
        wait_got(2);
        chk({PEER.got[0][7:0], PEER.got[1][7:0]}, 32'h1122);
        $display("command response test done");
        apb(1, 12'h000, 32'h005);
        apb(0, 12'h004, 32'h0);
        chk(q[0], 32'h1);
        host_rxd_pin <= 1'b0;
        repeat (4200) @(posedge pclk);
        chk({host_txd_pin, rf_tx_on}, 32'h1);
        host_rxd_pin <= 1'b1;
        repeat (4200) @(posedge pclk);
        chk(host_txd_pin, 32'h1);
        $display("transparent test done");
        tally_and_finish;
    end
endmodule // rmlc_top_tb_top
`default_nettype wire
